// *** rtl/decode_cfg.svh ***
// Encodings, field positions, reset values and timing counts for the decoder
`ifndef DECODE_CFG_SVH
`define DECODE_CFG_SVH
`define WORD_NO_OPERATION 12'h000
`define WORD_OPTION     12'h002
`define MOVE_ACC_MASK   12'hfe0
`define MOVE_ACC_CODE   12'h020
`define RET_LIT_CODE    4'h8
`define RET_LIT_TOP     11
`define RET_LIT_LOW     8
`define LIT_TOP         7
`define FILE_TOP        4
`define CORE_PER_INSN   4
`define RESET_ACC       8'h00
`define RESET_OPTION    8'hff
`define RESET_PHASE     2'h0
`define RESET_FILE_ADDR 5'h00
`define RESET_FILE_DATA 8'h00
`define RESET_PC        10'h000
`define PC_WIDTH        10
`define STACK_DEPTH     2
`endif

// *** rtl/decode_pkg.sv ***
// Types shared by the decoder files
package decode_pkg;
  typedef enum logic [1:0] {
    EXEC  = 2'b00,
    FLUSH = 2'b01
  } exec_state_t;
  typedef enum logic [2:0] {
    OP_NONE        = 3'h0,
    OP_NO_OPERATION = 3'h1,
    OP_MOVE_TO_FILE = 3'h2,
    OP_LOAD_OPTION = 3'h3,
    OP_RETURN_LIT  = 3'h4
  } op_t;
endpackage

// *** rtl/decode_if.sv ***
// Decoded instruction fields passed from the word classifier to the core
`timescale 1ns/100ps
`default_nettype none
interface decode_if;
  import decode_pkg::*;
  op_t        op;
  logic [7:0] literal;
  logic [4:0] file_addr;
  modport src (output op, output literal, output file_addr);
  modport dst (input op, input literal, input file_addr);
endinterface // decode_if
`default_nettype wire

// *** rtl/word_classify.sv ***
// Combinational classifier for the four handled instruction words
`timescale 1ns/100ps
`default_nettype none
`include "decode_cfg.svh"
module word_classify (
  // Fetched word
  input  wire logic [11:0] word,
  // Decoded fields
  decode_if.src            dec
);
  import decode_pkg::*;
  always_comb begin
    dec.literal   = word[`LIT_TOP:0];
    dec.file_addr = word[`FILE_TOP:0];
    if (word == `WORD_NO_OPERATION) begin
      dec.op = OP_NO_OPERATION;
    end else if (word == `WORD_OPTION) begin
      dec.op = OP_LOAD_OPTION;
    end else if ((word & `MOVE_ACC_MASK) == `MOVE_ACC_CODE) begin
      dec.op = OP_MOVE_TO_FILE;
    end else if (word[`RET_LIT_TOP:`RET_LIT_LOW] == `RET_LIT_CODE) begin
      dec.op = OP_RETURN_LIT;
    end else begin
      dec.op = OP_NONE;
    end
  end
endmodule // word_classify
`default_nettype wire

// *** rtl/move_nop_option_return_with_literal_decode.sv ***
// Execute logic for move-to-file, no-operation, load-option and return-with-literal
`timescale 1ns/100ps
`default_nettype none
`include "decode_cfg.svh"
module move_nop_option_return_with_literal_decode (
  // Clock and reset
  input  wire logic                      CLOCK,
  input  wire logic                      RST_N,
  input  wire logic                      CLK_EN,
  // Program memory word and stack
  input  wire logic [11:0]               INSN_WORD,
  input  wire logic [`PC_WIDTH-1:0]      STACK_TOP,
  input  wire logic [`PC_WIDTH-1:0]      PC_IN,
  // Accumulator seen from the core
  input  wire logic [7:0]                ACC_IN,
  // Results
  output logic      [7:0]                ACC,
  output logic      [7:0]                OPTION_REG,
  output logic                           FILE_WE,
  output logic      [4:0]                FILE_ADDR,
  output logic      [7:0]                FILE_DATA,
  output logic                           PC_LOAD,
  output logic      [`PC_WIDTH-1:0]      PC_NEXT,
  output logic                           STACK_POP,
  output logic                           INSN_CYCLE,
  output logic                           UNHANDLED
);
  import decode_pkg::*;

  // Decoded fields travel from the classifier in one bundle
  decode_if dec ();

  word_classify u_classify (
    .word (INSN_WORD),
    .dec  (dec)
  );

  // Phase counter state
  logic [1:0]           phase;
  logic [1:0]           next_phase;
  logic                 last_phase;
  // Sequencer state
  exec_state_t          state;
  exec_state_t          next_state;
  logic                 execute;
  // Accumulator and option state
  logic [7:0]           next_acc;
  logic [7:0]           next_option;
  // File write state
  logic                 next_file_we;
  logic [4:0]           next_file_addr;
  logic [7:0]           next_file_data;
  // Program counter and stack state
  logic                 next_pc_load;
  logic [`PC_WIDTH-1:0] next_pc;
  logic                 next_pop;
  // Foreign word state
  logic                 next_unhandled;

  // Words are only taken on the last of the four core clocks
  assign last_phase = (phase == 2'(`CORE_PER_INSN - 1));
  assign INSN_CYCLE = last_phase;
  // The word fetched behind a return is dropped, as the counter has moved on
  assign execute    = last_phase && (state == EXEC);

  // Phase counter
  always_comb begin
    if (last_phase) begin
      next_phase = 2'h0;
    end else begin
      next_phase = phase + 2'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      phase <= `RESET_PHASE;
    end else if (CLK_EN) begin
      phase <= next_phase;
    end
  end

  // Sequencer: a return steals the following instruction cycle
  always_comb begin
    next_state = state;
    if (last_phase) begin
      case (state)
        EXEC: begin
          if (dec.op == OP_RETURN_LIT) begin
            next_state = FLUSH;
          end else begin
            next_state = EXEC;
          end
        end
        FLUSH: begin
          next_state = EXEC;
        end
        default: begin
          next_state = EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= EXEC;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  // Accumulator and option; no status flags live here, so none can change
  always_comb begin
    next_acc    = ACC;
    next_option = OPTION_REG;
    if (execute) begin
      case (dec.op)
        OP_LOAD_OPTION: begin
          next_option = ACC_IN;
        end
        OP_RETURN_LIT: begin
          next_acc = dec.literal;
        end
        OP_NO_OPERATION: begin
          next_acc = ACC;
        end
        default: begin
          next_acc    = ACC;
          next_option = OPTION_REG;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ACC        <= `RESET_ACC;
      OPTION_REG <= `RESET_OPTION;
    end else if (CLK_EN) begin
      ACC        <= next_acc;
      OPTION_REG <= next_option;
    end
  end

  // File write: strobe lasts one core clock, address and data hold
  always_comb begin
    next_file_we   = 1'b0;
    next_file_addr = FILE_ADDR;
    next_file_data = FILE_DATA;
    if (execute && (dec.op == OP_MOVE_TO_FILE)) begin
      next_file_we   = 1'b1;
      next_file_addr = dec.file_addr;
      next_file_data = ACC_IN;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      FILE_WE   <= 1'b0;
      FILE_ADDR <= `RESET_FILE_ADDR;
      FILE_DATA <= `RESET_FILE_DATA;
    end else if (CLK_EN) begin
      FILE_WE   <= next_file_we;
      FILE_ADDR <= next_file_addr;
      FILE_DATA <= next_file_data;
    end
  end

  // Program counter and stack; a foreign word only reports the current count
  always_comb begin
    next_pc_load = 1'b0;
    next_pc      = PC_NEXT;
    next_pop     = 1'b0;
    if (execute) begin
      case (dec.op)
        OP_RETURN_LIT: begin
          next_pc_load = 1'b1;
          next_pc      = STACK_TOP;
          next_pop     = 1'b1;
        end
        OP_NONE: begin
          next_pc = PC_IN;
        end
        default: begin
          next_pc = PC_NEXT;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PC_LOAD   <= 1'b0;
      PC_NEXT   <= `RESET_PC;
      STACK_POP <= 1'b0;
    end else if (CLK_EN) begin
      PC_LOAD   <= next_pc_load;
      PC_NEXT   <= next_pc;
      STACK_POP <= next_pop;
    end
  end

  // Foreign words belong to other decoders
  always_comb begin
    next_unhandled = execute && (dec.op == OP_NONE);
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      UNHANDLED <= 1'b0;
    end else if (CLK_EN) begin
      UNHANDLED <= next_unhandled;
    end
  end
endmodule // move_nop_option_return_with_literal_decode
`default_nettype wire

// *** bench/prog_mem.sv ***
// Program memory model feeding instruction words
`timescale 1ns/100ps
`default_nettype none
module prog_mem (
  // Fetch phase and address
  input  wire logic        INSN_CYCLE,
  input  wire logic [3:0]  addr,
  // Word to the decoder
  output logic      [11:0] word
);
  logic [11:0] rom [0:15] = '{12'h000, 12'h03f, 12'h002, 12'h8a5,
                              12'h03f, 12'h020, 12'h8ff, 12'h800,
                              12'h003, 12'h0ff, 12'h000, 12'h000,
                              12'h000, 12'h000, 12'h000, 12'h000};
  // Word is only valid in the fetch phase, so it shows its inverse elsewhere
  assign word = INSN_CYCLE ? rom[addr] : ~rom[addr];
endmodule // prog_mem
`default_nettype wire

// *** bench/decode_properties.sv ***
// Assertions on the decoder ports
`timescale 1ns/100ps
`default_nettype none
`include "decode_cfg.svh"
module decode_properties (
  // Clock, reset and enable
  input wire logic                 CLOCK,
  input wire logic                 RST_N,
  input wire logic                 CLK_EN,
  // Inputs of the decoder
  input wire logic [11:0]          INSN_WORD,
  input wire logic [`PC_WIDTH-1:0] STACK_TOP,
  input wire logic [`PC_WIDTH-1:0] PC_IN,
  input wire logic [7:0]           ACC_IN,
  // Outputs of the decoder
  input wire logic                 INSN_CYCLE,
  input wire logic                 FILE_WE,
  input wire logic                 PC_LOAD,
  input wire logic                 STACK_POP,
  input wire logic                 UNHANDLED,
  input wire logic [`PC_WIDTH-1:0] PC_NEXT,
  input wire logic [7:0]           ACC,
  input wire logic [7:0]           OPTION_REG,
  input wire logic [7:0]           FILE_DATA,
  input wire logic [4:0]           FILE_ADDR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic tk;
  logic skip;
  assign tk = CLK_EN && INSN_CYCLE;
  // The word after a return is discarded, so execution checks must skip it
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) skip <= 1'b0;
    else if (tk) skip <= !skip && INSN_WORD[11:8] == 4'h8;
  end
  sequence live; tk && !skip; endsequence
  sequence ret; live ##0 INSN_WORD[11:8] == 4'h8; endsequence
  sequence idle; !FILE_WE && !PC_LOAD && $stable(OPTION_REG) && $stable(ACC); endsequence
  sequence foreign;
    live ##0 INSN_WORD != 12'h000 && INSN_WORD != 12'h002
      && (INSN_WORD & 12'hfe0) != 12'h020 && INSN_WORD[11:8] != 4'h8;
  endsequence
  AST_RET_ACC: assert property (ret |=> ACC == $past(INSN_WORD[7:0]))
    else $error("literal not in accumulator");
  AST_RET_PC: assert property (ret |=> PC_LOAD && STACK_POP && PC_NEXT == $past(STACK_TOP))
    else $error("return address not loaded");
  AST_OPT: assert property (live ##0 INSN_WORD == 12'h002 |=> OPTION_REG == $past(ACC_IN))
    else $error("option not loaded");
  AST_MOV: assert property (live ##0 (INSN_WORD & 12'hfe0) == 12'h020 |=> FILE_WE
    && FILE_ADDR == $past(INSN_WORD[4:0]) && FILE_DATA == $past(ACC_IN))
    else $error("file write wrong");
  AST_FLUSH: assert property (tk && skip |=> idle)
    else $error("discarded word acted");
  AST_NOP: assert property (live ##0 INSN_WORD == 12'h000 |=> idle)
    else $error("no-operation acted");
  AST_CYC: assert property (INSN_CYCLE ##0 CLK_EN [*4] |=> INSN_CYCLE)
    else $error("cycle not four clocks");
  AST_GAP: assert property (tk |=> !INSN_CYCLE)
    else $error("phase repeated");
  AST_FOREIGN: assert property (foreign |=> UNHANDLED && PC_NEXT == $past(PC_IN))
    else $error("foreign word not reported");
endmodule // decode_properties
bind move_nop_option_return_with_literal_decode decode_properties decode_properties_i (.CLOCK, .RST_N,
  .CLK_EN, .INSN_WORD, .STACK_TOP, .PC_IN, .ACC_IN, .INSN_CYCLE, .FILE_WE, .PC_LOAD,
  .STACK_POP, .UNHANDLED, .PC_NEXT, .ACC, .OPTION_REG, .FILE_DATA, .FILE_ADDR);
`default_nettype wire

// *** bench/move_nop_option_return_with_literal_decode_tb.sv ***
// Testbench for the decoder
`timescale 1ns/100ps
`default_nettype none
`include "decode_cfg.svh"
module move_nop_option_return_with_literal_decode_tb;
  logic CLOCK = 0, RST_N = 0, CLK_EN = 1, INSN_CYCLE, FILE_WE, PC_LOAD, STACK_POP, UNHANDLED;
  logic [3:0] addr = 0;
  logic [11:0] INSN_WORD;
  logic [`PC_WIDTH-1:0] STACK_TOP = 0, PC_IN = 0, PC_NEXT;
  logic [7:0] ACC_IN = 0, ACC, OPTION_REG, FILE_DATA;
  logic [4:0] FILE_ADDR;
  int fail_count = 0, check_count = 0;
  prog_mem prog_mem_i (.INSN_CYCLE, .addr, .word(INSN_WORD));
  move_nop_option_return_with_literal_decode move_nop_option_return_with_literal_decode_i (.CLOCK, .RST_N, .CLK_EN,
    .INSN_WORD, .STACK_TOP, .PC_IN, .ACC_IN, .ACC, .OPTION_REG, .FILE_WE, .FILE_ADDR,
    .FILE_DATA, .PC_LOAD, .PC_NEXT, .STACK_POP, .INSN_CYCLE, .UNHANDLED);
  initial forever #20 CLOCK = ~CLOCK;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Present one word in the fetch phase, look just after the take edge
  task automatic op(logic [3:0] a, logic [7:0] acc, logic [9:0] top, logic [9:0] pc);
    repeat (3) @(posedge CLOCK);
    addr <= a;
    ACC_IN <= acc;
    STACK_TOP <= top;
    PC_IN <= pc;
    @(posedge CLOCK);
    @(negedge CLOCK);
  endtask
  task automatic t_option;
    op(4'h2, 8'h5c, 10'h000, 10'h000);
    chk("option", OPTION_REG, 8'h5c);
  endtask
  task automatic t_move;
    op(4'h1, 8'h4f, 10'h000, 10'h000);
    chk("we", FILE_WE, 32'h1);
    chk("addr", FILE_ADDR, 5'h1f);
    chk("data", FILE_DATA, 8'h4f);
  endtask
  task automatic t_nop;
    op(4'h0, 8'h11, 10'h000, 10'h000);
    chk("nop", {FILE_WE, PC_LOAD, OPTION_REG}, 10'h05c);
  endtask
  task automatic t_return;
    op(4'h3, 8'h00, 10'h155, 10'h000);
    chk("acc", ACC, 8'ha5);
    chk("pc", {PC_LOAD, STACK_POP, PC_NEXT}, 12'hd55);
    op(4'h4, 8'h66, 10'h000, 10'h000);
    chk("flush", {FILE_WE, PC_LOAD}, 2'h0);
    op(4'h5, 8'h77, 10'h000, 10'h000);
    chk("after", {FILE_WE, FILE_ADDR, FILE_DATA}, 14'h2077);
  endtask
  task automatic t_back;
    op(4'h6, 8'h00, 10'h3ff, 10'h000);
    chk("acc max", ACC, 8'hff);
    op(4'h2, 8'h99, 10'h000, 10'h000);
    chk("skip opt", OPTION_REG, 8'h5c);
    op(4'h7, 8'h00, 10'h001, 10'h000);
    chk("acc min", {ACC, PC_NEXT}, 18'h00001);
  endtask
  // Words outside the four are reported unless fetched behind a return, never executed
  task automatic t_foreign;
    op(4'h8, 8'h33, 10'h000, 10'h111);
    chk("drop foreign", {UNHANDLED, PC_NEXT}, 11'h001);
    op(4'h8, 8'h34, 10'h000, 10'h2a6);
    chk("foreign a", {UNHANDLED, PC_LOAD, PC_NEXT}, 12'haa6);
    op(4'h9, 8'h35, 10'h000, 10'h059);
    chk("foreign b", {UNHANDLED, PC_LOAD, PC_NEXT}, 12'h859);
    chk("foreign keep", {FILE_WE, ACC, OPTION_REG}, 17'h0005c);
  endtask
  // A low enable holds the fetch phase and the option register
  task automatic t_freeze;
    repeat (3) @(posedge CLOCK);
    addr <= 4'h2;
    ACC_IN <= 8'ha3;
    CLK_EN <= 1'b0;
    repeat (5) @(posedge CLOCK);
    CLK_EN <= 1'b1;
    @(negedge CLOCK);
    chk("frozen opt", OPTION_REG, 8'h5c);
    chk("frozen cyc", INSN_CYCLE, 32'h1);
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk("thawed opt", OPTION_REG, 8'ha3);
    chk("thawed cyc", INSN_CYCLE, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge CLOCK);
    RST_N <= 1;
    repeat (8) if (INSN_CYCLE !== 1'b1) @(negedge CLOCK);
    if (INSN_CYCLE !== 1'b1) begin
      fail_count++;
      final_report;
    end
    @(posedge CLOCK);
    @(negedge CLOCK);
    t_option;
    t_move;
    t_nop;
    t_return;
    t_back;
    t_foreign;
    t_freeze;
    final_report;
  end
endmodule // move_nop_option_return_with_literal_decode_tb
`default_nettype wire
